//--- core/tcp_pkg.sv
// register map, field layout, reset values and timing counts of the timer pair block
package tcp_pkg;
  // apb window
  localparam int ADDR_W = 8;
  localparam logic [7:0] PAIR_A_BASE = 8'h00;
  localparam logic [7:0] PAIR_B_BASE = 8'h20;
  localparam logic [7:0] OFS_PORT_SEL = 8'h40;
  // register index inside one pair, byte offset is base + 4 * index
  localparam logic [2:0] IDX_LO_MODE = 3'h0;
  localparam logic [2:0] IDX_HI_MODE = 3'h1;
  localparam logic [2:0] IDX_CMP_LO = 3'h2;
  localparam logic [2:0] IDX_CMP_HI = 3'h3;
  localparam logic [2:0] IDX_PER_LO = 3'h4;
  localparam logic [2:0] IDX_DUTY_LO = 3'h5;
  localparam logic [2:0] IDX_HIGH_BITS = 3'h6;
  localparam logic [2:0] IDX_COUNT = 3'h7;
  // lower timer mode fields
  localparam int LO_CS_LSB = 0;
  localparam int LO_CAP_BIT = 3;
  localparam int LO_RUN_BIT = 4;
  // upper timer mode fields
  localparam int HI_CS_LSB = 0;
  localparam int HI_CAP_BIT = 2;
  localparam int HI_CASC_BIT = 3;
  localparam int HI_PWM_BIT = 4;
  localparam int HI_POL_BIT = 5;
  localparam int HI_RUN_BIT = 6;
  // port select fields
  localparam int PS_PWM_A_OE_BIT = 0;
  localparam int PS_PWM_B_OE_BIT = 1;
  localparam int PS_EDGE_A_LSB = 2;
  localparam int PS_EDGE_C_LSB = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // capture edge selection
  typedef enum logic [1:0] {
    TCP_EDGE_NONE,
    TCP_EDGE_FALL,
    TCP_EDGE_RISE,
    TCP_EDGE_BOTH
  } tcp_edge_t;
  // upper timer source clock periods, rounded up to whole pclk cycles
  localparam int CLK_MHZ = 50;
  localparam int SRC0_NS = 250;
  localparam int SRC1_NS = 500;
  localparam int SRC2_NS = 2000;
  localparam logic [6:0] SRC0_CYC = 7'((SRC0_NS * CLK_MHZ + 999) / 1000);
  localparam logic [6:0] SRC1_CYC = 7'((SRC1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [6:0] SRC2_CYC = 7'((SRC2_NS * CLK_MHZ + 999) / 1000);
endpackage : tcp_pkg

//--- core/tcp_timer_block.sv
// cascadable timer pairs with 16-bit capture and 10-bit pwm, behind an apb slave
// Notes on behaviour
// (RULE1) cascaded 16-bit capture works like 8-bit capture with 16-bit count and value
// (RULE2) first pair cascades when upper clock bits, capture and cascade bits are set
// (RULE3) second pair cascades the same way; lower clock select picks the source
// (RULE4) two pwm channels reuse the upper timers, each drives its own pin
// (RULE5) pwm pin carries the waveform only while its output enable bit is one
// (RULE6) 10-bit period is high bits 3..2 over the 8-bit period low value
// (RULE7) 10-bit duty is high bits 1..0 over the 8-bit duty low value
// (RULE8) written duty copies to the active duty only on period match; the code also copies it every cycle while pwm mode is off
// (RULE9) period and duty time count in selected source clock cycles
// (RULE10) source clock selects 00, 01, 10 give 250 ns, 500 ns, 2 us; select 00 here is 13 pclk cycles, 260 ns
// (RULE11) polarity bit chooses whether the duty part is high or low
// (RULE12) duty equal to period holds the pin at the polarity level
// (RULE13) zero duty holds the pin at the inverse of polarity
// (RULE14) a duty write during pwm takes effect after the current period
// (RULE15) changing only the period keeps the duty time; period must exceed duty
// (RULE16) software stops the timer before loading period and duty values
// (RULE17) capture edge copies count, clears and restarts timer, raises an event
// (RULE18) in capture mode the compare address reads the captured value
// (RULE19) cascaded counter counts to the 16-bit compare, clears, raises lower event
// (RULE20) pwm counter clears on period match; duty level from start to duty
`timescale 1ns/1ns

// one lower/upper timer pair with capture and pwm
module tcp_pair (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reg_we,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] wdata,
  output logic [15:0] rdata,
  input wire logic event_pin,
  input wire logic cap_pin,
  input wire logic [1:0] edge_sel,
  input wire logic pwm_oe,
  output logic pwm_pin,
  output logic pwm_pin_oe,
  output logic lo_match_pulse,
  output logic hi_match_pulse,
  output logic cap_pulse
);
  logic [7:0] lo_mode_reg;
  logic [7:0] hi_mode_reg;
  logic [7:0] cmp_lo_reg;
  logic [7:0] cmp_hi_reg;
  logic [7:0] per_lo_reg;
  logic [7:0] duty_lo_reg;
  logic [3:0] high_bits_reg;
  logic [7:0] cnt_lo_reg;
  logic [7:0] cnt_hi_reg;
  logic [15:0] cap_reg;
  logic [9:0] pwm_cnt_reg;
  logic [9:0] duty_act_reg;
  logic [10:0] pre_reg;
  logic [6:0] div_reg;
  logic cap_prev_reg;
  logic event_prev_reg;
  logic pwm_out_reg;
  logic lo_match_reg;
  logic hi_match_reg;
  logic cap_pulse_reg;
  logic casc;
  logic cap_mode;
  logic pwm_mode;
  logic duty_polarity;
  logic lo_run;
  logic hi_run;
  logic pre_hit;
  logic lo_tick;
  logic div_done;
  logic hi_tick;
  logic pwm_tick;
  logic [6:0] div_max;
  logic [15:0] cnt16;
  logic [15:0] cmp16;
  logic lo_match;
  logic hi_match;
  logic edge_hit;
  logic cap_evt;
  logic [9:0] per10;
  logic [9:0] duty10;
  logic per_match;
  logic wave;

  // mode decode
  assign casc = hi_mode_reg[tcp_pkg::HI_CASC_BIT];
  assign pwm_mode = hi_mode_reg[tcp_pkg::HI_PWM_BIT] & ~casc;
  assign duty_polarity = hi_mode_reg[tcp_pkg::HI_POL_BIT];
  assign lo_run = lo_mode_reg[tcp_pkg::LO_RUN_BIT];
  assign hi_run = hi_mode_reg[tcp_pkg::HI_RUN_BIT];
  // cascaded capture needs the upper capture bit as well as the lower one
  assign cap_mode = lo_mode_reg[tcp_pkg::LO_CAP_BIT] & (~casc | hi_mode_reg[tcp_pkg::HI_CAP_BIT]); // see (RULE2) (RULE3)
  assign cnt16 = {cnt_hi_reg, cnt_lo_reg};
  assign cmp16 = {cmp_hi_reg, cmp_lo_reg};
  assign per10 = {high_bits_reg[3:2], per_lo_reg}; // see (RULE6)
  assign duty10 = {high_bits_reg[1:0], duty_lo_reg}; // see (RULE7)

  // lower timer source: prescaler taps 2..2048 or rising edges of the event pin
  always_comb begin
    case (lo_mode_reg[tcp_pkg::LO_CS_LSB +: 3])
      3'h0: pre_hit = &pre_reg[0:0];
      3'h1: pre_hit = &pre_reg[1:0];
      3'h2: pre_hit = &pre_reg[2:0];
      3'h3: pre_hit = &pre_reg[4:0];
      3'h4: pre_hit = &pre_reg[6:0];
      3'h5: pre_hit = &pre_reg[8:0];
      3'h6: pre_hit = &pre_reg[10:0];
      default: pre_hit = event_pin & ~event_prev_reg;
    endcase
  end
  assign lo_tick = lo_run & pre_hit;

  // upper timer source period in pclk cycles
  always_comb begin
    case (hi_mode_reg[tcp_pkg::HI_CS_LSB +: 2])
      2'h0: div_max = tcp_pkg::SRC0_CYC; // see (RULE10)
      2'h1: div_max = tcp_pkg::SRC1_CYC; // see (RULE10)
      default: div_max = tcp_pkg::SRC2_CYC; // see (RULE10)
    endcase
  end
  assign div_done = div_reg >= div_max - 7'h01;
  assign hi_tick = hi_run & div_done & ~casc & ~pwm_mode;
  assign pwm_tick = hi_run & div_done & pwm_mode; // see (RULE9)

  // free prescaler and upper source divider; a stopped timer parks its divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
      div_reg <= '0;
      event_prev_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 11'h001;
      event_prev_reg <= event_pin;
      if (!hi_run || div_done) begin
        div_reg <= '0;
      end else begin
        div_reg <= div_reg + 7'h01;
      end
    end
  end

  // capture edge detection on the interrupt pin
  always_comb begin
    case (tcp_pkg::tcp_edge_t'(edge_sel))
      tcp_pkg::TCP_EDGE_FALL: edge_hit = cap_prev_reg & ~cap_pin;
      tcp_pkg::TCP_EDGE_RISE: edge_hit = ~cap_prev_reg & cap_pin;
      tcp_pkg::TCP_EDGE_BOTH: edge_hit = cap_prev_reg ^ cap_pin;
      default: edge_hit = 1'b0;
    endcase
  end
  assign cap_evt = cap_mode & lo_run & edge_hit;

  // match against 8-bit or cascaded 16-bit compare value
  assign lo_match = casc ? (cnt16 == cmp16) : (cnt_lo_reg == cmp_lo_reg); // see (RULE19)
  assign hi_match = cnt_hi_reg == cmp_hi_reg;

  // software registers; writes while running are taken as they come
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_mode_reg <= tcp_pkg::RST_BYTE;
      hi_mode_reg <= tcp_pkg::RST_BYTE;
      cmp_lo_reg <= tcp_pkg::RST_BYTE;
      cmp_hi_reg <= tcp_pkg::RST_BYTE;
      per_lo_reg <= tcp_pkg::RST_BYTE;
      duty_lo_reg <= tcp_pkg::RST_BYTE;
      high_bits_reg <= '0;
    end else if (reg_we) begin
      if (reg_idx == tcp_pkg::IDX_LO_MODE) begin
        lo_mode_reg <= wdata;
      end else if (reg_idx == tcp_pkg::IDX_HI_MODE) begin
        hi_mode_reg <= wdata;
      end else if (reg_idx == tcp_pkg::IDX_CMP_LO) begin
        cmp_lo_reg <= wdata;
      end else if (reg_idx == tcp_pkg::IDX_CMP_HI) begin
        cmp_hi_reg <= wdata;
      end else if (reg_idx == tcp_pkg::IDX_PER_LO) begin
        per_lo_reg <= wdata; // see (RULE15)
      end else if (reg_idx == tcp_pkg::IDX_DUTY_LO) begin
        duty_lo_reg <= wdata;
      end else if (reg_idx == tcp_pkg::IDX_HIGH_BITS) begin
        high_bits_reg <= wdata[3:0];
      end
    end
  end

  // timer counters; capture clears and restarts, match clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_reg <= '0;
      cnt_hi_reg <= '0;
    end else begin
      if (cap_evt) begin
        cnt_lo_reg <= '0; // see (RULE17)
        if (casc) begin
          cnt_hi_reg <= '0;
        end
      end else if (lo_tick) begin
        if (lo_match) begin
          cnt_lo_reg <= '0; // see (RULE19)
          if (casc) begin
            cnt_hi_reg <= '0;
          end
        end else if (casc) begin
          {cnt_hi_reg, cnt_lo_reg} <= cnt16 + 16'h0001;
        end else begin
          cnt_lo_reg <= cnt_lo_reg + 8'h01;
        end
      end
      if (hi_tick) begin
        cnt_hi_reg <= hi_match ? 8'h00 : cnt_hi_reg + 8'h01;
      end
    end
  end

  // capture register and event pulses, one pclk each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= '0;
      cap_prev_reg <= 1'b0;
      cap_pulse_reg <= 1'b0;
      lo_match_reg <= 1'b0;
      hi_match_reg <= 1'b0;
    end else begin
      cap_prev_reg <= cap_pin;
      cap_pulse_reg <= cap_evt; // see (RULE17)
      lo_match_reg <= lo_tick & lo_match & ~cap_evt; // see (RULE19)
      hi_match_reg <= hi_tick & hi_match;
      if (cap_evt) begin
        cap_reg <= casc ? cnt16 : {8'h00, cnt_lo_reg}; // see (RULE1)
      end
    end
  end

  // pwm counter; in pwm mode the duty copy moves only at period match so a cycle never glitches
  assign per_match = pwm_cnt_reg == per10;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_reg <= '0;
      duty_act_reg <= '0;
    end else if (!pwm_mode) begin
      pwm_cnt_reg <= '0;
      duty_act_reg <= duty10;
    end else if (pwm_tick) begin
      if (per_match) begin
        pwm_cnt_reg <= '0; // see (RULE20)
        duty_act_reg <= duty10; // see (RULE8) (RULE14)
      end else begin
        pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
      end
    end
  end

  // duty level runs from cycle start up to the active duty count
  assign wave = ((duty_act_reg != 10'h000) && (pwm_cnt_reg <= duty_act_reg)) ? duty_polarity : ~duty_polarity; // see (RULE11) (RULE12) (RULE13)

  // pin register; a disabled pin is parked low and undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_reg <= 1'b0;
    end else begin
      pwm_out_reg <= pwm_oe & pwm_mode & wave; // see (RULE5)
    end
  end

  // read mux; capture mode opens the compare address onto the captured value
  always_comb begin
    rdata = 16'h0000;
    if (reg_idx == tcp_pkg::IDX_LO_MODE) begin
      rdata = {8'h00, lo_mode_reg};
    end else if (reg_idx == tcp_pkg::IDX_HI_MODE) begin
      rdata = {8'h00, hi_mode_reg};
    end else if (reg_idx == tcp_pkg::IDX_CMP_LO) begin
      rdata = {8'h00, cap_mode ? cap_reg[7:0] : cmp_lo_reg}; // see (RULE18)
    end else if (reg_idx == tcp_pkg::IDX_CMP_HI) begin
      rdata = {8'h00, cap_mode ? cap_reg[15:8] : cmp_hi_reg}; // see (RULE18)
    end else if (reg_idx == tcp_pkg::IDX_PER_LO) begin
      rdata = {8'h00, per_lo_reg};
    end else if (reg_idx == tcp_pkg::IDX_DUTY_LO) begin
      rdata = {8'h00, duty_lo_reg};
    end else if (reg_idx == tcp_pkg::IDX_HIGH_BITS) begin
      rdata = {12'h000, high_bits_reg};
    end else begin
      rdata = pwm_mode ? {6'h00, pwm_cnt_reg} : cnt16;
    end
  end

  assign pwm_pin = pwm_out_reg;
  assign pwm_pin_oe = pwm_oe; // see (RULE5)
  assign lo_match_pulse = lo_match_reg;
  assign hi_match_pulse = hi_match_reg;
  assign cap_pulse = cap_pulse_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pin_gated_off: assert property (!pwm_oe |=> !pwm_pin) // see (RULE5)
    else $error("pwm pin active while output disabled");
  a_duty_swap_match: assert property (pwm_mode && pwm_tick && per_match |=> duty_act_reg == $past(duty10)) // see (RULE8)
    else $error("duty copy not taken at period match");
  a_duty_held_mid: assert property (pwm_mode && !(pwm_tick && per_match) ##1 pwm_mode |-> $stable(duty_act_reg)) // see (RULE14)
    else $error("active duty changed inside a period");
  a_full_duty_pin: assert property (pwm_oe && pwm_mode && duty_act_reg == per10 |=> pwm_pin == $past(duty_polarity)) // see (RULE12)
    else $error("full duty pin not at polarity level");
  a_zero_duty_pin: assert property (pwm_oe && pwm_mode && duty_act_reg == 10'h000 |=> pwm_pin == !$past(duty_polarity)) // see (RULE13)
    else $error("zero duty pin not at inverse polarity");
  a_pwm_wrap_zero: assert property (pwm_mode && pwm_tick && per_match ##1 pwm_mode |-> pwm_cnt_reg == 10'h000) // see (RULE20)
    else $error("pwm counter did not clear at period");
  a_pwm_tick_only: assert property (pwm_mode && !pwm_tick ##1 pwm_mode |-> $stable(pwm_cnt_reg)) // see (RULE9)
    else $error("pwm counter moved without a source tick");
  a_capture_copy: assert property (cap_evt && casc |=> cap_reg == $past(cnt16) && cnt16 == 16'h0000 && cap_pulse) // see (RULE17)
    else $error("capture did not copy and clear the count");
  a_cascade_wrap: assert property (lo_tick && casc && lo_match && !cap_evt |=> cnt16 == 16'h0000 && lo_match_pulse) // see (RULE19)
    else $error("cascaded counter did not clear at match");
endmodule : tcp_pair

// apb slave with two timer pairs and the port select register
module tcp_timer_block (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_a_pin,
  input wire logic event_c_pin,
  input wire logic cap_a_pin,
  input wire logic cap_c_pin,
  output logic pwm_a_pin,
  output logic pwm_a_pin_oe,
  output logic pwm_b_pin,
  output logic pwm_b_pin_oe,
  output logic timer_a_match,
  output logic timer_b_match,
  output logic timer_c_match,
  output logic timer_d_match,
  output logic capture_a_event,
  output logic capture_c_event
);
  logic [7:0] port_select_reg;
  logic [31:0] prdata_reg;
  logic [15:0] rdata_a;
  logic [15:0] rdata_c;
  logic hit_a;
  logic hit_c;
  logic hit_ps;
  logic mapped;
  logic wr_go;
  logic [31:0] rd_mux;

  // address decode, aligned words only
  assign hit_a = (paddr[7:5] == tcp_pkg::PAIR_A_BASE[7:5]) && (paddr[1:0] == 2'h0);
  assign hit_c = (paddr[7:5] == tcp_pkg::PAIR_B_BASE[7:5]) && (paddr[1:0] == 2'h0);
  assign hit_ps = paddr == tcp_pkg::OFS_PORT_SEL;
  assign mapped = hit_a | hit_c | hit_ps;
  assign wr_go = psel & penable & pwrite & mapped;

  // zero wait states: the answer is in the first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_select_reg <= tcp_pkg::RST_BYTE;
    end else if (wr_go && hit_ps) begin
      port_select_reg <= pwdata[7:0];
    end
  end

  // read data sampled in the setup cycle, so it is stable through the access cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_a) begin
      rd_mux = {16'h0000, rdata_a};
    end else if (hit_c) begin
      rd_mux = {16'h0000, rdata_c};
    end else if (hit_ps) begin
      rd_mux = {24'h00_0000, port_select_reg};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;

  // first pair; its upper timer is pwm channel a
  tcp_pair u_pair_a ( // see (RULE4)
    .pclk(pclk),
    .presetn(presetn),
    .reg_we(wr_go & hit_a),
    .reg_idx(paddr[4:2]),
    .wdata(pwdata[7:0]),
    .rdata(rdata_a),
    .event_pin(event_a_pin),
    .cap_pin(cap_a_pin),
    .edge_sel(port_select_reg[tcp_pkg::PS_EDGE_A_LSB +: 2]),
    .pwm_oe(port_select_reg[tcp_pkg::PS_PWM_A_OE_BIT]),
    .pwm_pin(pwm_a_pin),
    .pwm_pin_oe(pwm_a_pin_oe),
    .lo_match_pulse(timer_a_match),
    .hi_match_pulse(timer_b_match),
    .cap_pulse(capture_a_event)
  );

  // second pair; its upper timer is pwm channel b
  tcp_pair u_pair_c ( // see (RULE4)
    .pclk(pclk),
    .presetn(presetn),
    .reg_we(wr_go & hit_c),
    .reg_idx(paddr[4:2]),
    .wdata(pwdata[7:0]),
    .rdata(rdata_c),
    .event_pin(event_c_pin),
    .cap_pin(cap_c_pin),
    .edge_sel(port_select_reg[tcp_pkg::PS_EDGE_C_LSB +: 2]),
    .pwm_oe(port_select_reg[tcp_pkg::PS_PWM_B_OE_BIT]),
    .pwm_pin(pwm_b_pin),
    .pwm_pin_oe(pwm_b_pin_oe),
    .lo_match_pulse(timer_c_match),
    .hi_match_pulse(timer_d_match),
    .cap_pulse(capture_c_event)
  );
endmodule : tcp_timer_block

//--- verification/tcp_timer_block_tb.sv
// self-checking apb testbench for the timer pair block: pwm waveforms, 16-bit match and capture
`timescale 1ns/1ns
module tcp_timer_block_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic event_a_pin;
  logic event_c_pin;
  logic cap_a_pin;
  logic cap_c_pin;
  logic pwm_a_pin;
  logic pwm_a_pin_oe;
  logic pwm_b_pin;
  logic pwm_b_pin_oe;
  logic timer_a_match;
  logic timer_b_match;
  logic timer_c_match;
  logic timer_d_match;
  logic capture_a_event;
  logic capture_c_event;
  int errors;
  int comparisons;
  int c0;
  int cyc[3];
  logic [31:0] rd;
  logic er;
  int n;
  logic [3:0] pulses;

  // the four match outputs, indexed a, b, c, d
  assign pulses = {timer_d_match, timer_c_match, timer_b_match, timer_a_match};

  tcp_timer_block tcp_timer_block_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_a_pin(event_a_pin), .event_c_pin(event_c_pin), .cap_a_pin(cap_a_pin), .cap_c_pin(cap_c_pin),
    .pwm_a_pin(pwm_a_pin), .pwm_a_pin_oe(pwm_a_pin_oe), .pwm_b_pin(pwm_b_pin), .pwm_b_pin_oe(pwm_b_pin_oe),
    .timer_a_match(timer_a_match), .timer_b_match(timer_b_match), .timer_c_match(timer_c_match),
    .timer_d_match(timer_d_match), .capture_a_event(capture_a_event), .capture_c_event(capture_c_event)
  );

  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  // event input of the second pair: a rising edge every second cycle, parked low in reset
  always @(posedge pclk) begin
    event_c_pin <= presetn ? ~event_c_pin : 1'b0;
  end

  // byte address of a register inside one pair
  function automatic logic [7:0] ra(input logic [7:0] b, input logic [2:0] idx);
    ra = b + 8'({idx, 2'b00});
  endfunction : ra

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // one apb transfer; the request is held until pready is seen high at a rising edge
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0000_00, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_write(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
  endtask : apb_write

  task automatic apb_read(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b0, a, 8'h00, r, e);
    chk(r, exp, m);
  endtask : apb_read

  // timer is stopped before period and duty are loaded, then started in pwm mode
  task automatic pwm_cfg(input logic [7:0] b, input logic [1:0] cs, input logic [9:0] per,
                         input logic [9:0] dut, input logic duty_polarity);
    apb_write(ra(b, tcp_pkg::IDX_HI_MODE), 8'h00);
    apb_write(ra(b, tcp_pkg::IDX_PER_LO), per[7:0]);
    apb_write(ra(b, tcp_pkg::IDX_DUTY_LO), dut[7:0]);
    apb_write(ra(b, tcp_pkg::IDX_HIGH_BITS), {4'h0, per[9:8], dut[9:8]});
    apb_write(ra(b, tcp_pkg::IDX_HI_MODE), {1'b0, 1'b1, duty_polarity, 1'b1, 2'b00, cs});
  endtask : pwm_cfg

  // settle one window, then count high cycles over a whole number of pwm periods
  task automatic pwm_check(input logic ch, input int win, input int exp_hi);
    int hi;
    hi = 0;
    repeat (win) @(posedge pclk);
    repeat (win) begin
      @(negedge pclk);
      if ((ch ? pwm_b_pin : pwm_a_pin) === 1'b1) hi++;
    end
    chk(32'(hi), 32'(exp_hi), "pwm high time");
  endtask : pwm_check

  // wait for one pulse of the chosen match output, then count cycles up to the next one
  task automatic gap(input int s, output int cnt);
    for (int k = 0; k < 2; k++) begin
      cnt = 0;
      do begin
        @(negedge pclk);
        cnt++;
      end while (pulses[s] !== 1'b1 && cnt < 1100);
    end
  endtask : gap

  // watchdog: the whole sequence needs well under 40000 cycles
  initial begin
    repeat (80000) @(posedge pclk);
    errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    final_report();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    event_a_pin = 1'b0;
    cap_a_pin = 1'b1;
    cap_c_pin = 1'b0;
    c0 = int'(tcp_pkg::SRC0_CYC);
    cyc = '{int'(tcp_pkg::SRC0_CYC), int'(tcp_pkg::SRC1_CYC), int'(tcp_pkg::SRC2_CYC)};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused addresses
    apb_read(tcp_pkg::OFS_PORT_SEL, 32'h0000_0000, "port select reset");
    apb_read(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_HI_MODE), 32'h0000_0000, "mode reset");
    chk(pwm_a_pin_oe, 1'b0, "oe after reset");
    apb_xfer(1'b0, 8'h44, 8'h00, rd, er);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    apb_xfer(1'b1, 8'h41, 8'h03, rd, er);
    chk(er, 1'b1, "unaligned error");
    // pin stays quiet until its output enable is set
    pwm_cfg(tcp_pkg::PAIR_A_BASE, 2'b00, 10'd3, 10'd3, 1'b1);
    pwm_check(1'b0, 4 * c0, 0);
    apb_write(tcp_pkg::OFS_PORT_SEL, 8'h03);
    apb_read(tcp_pkg::OFS_PORT_SEL, 32'h0000_0003, "port select readback");
    chk(pwm_a_pin_oe, 1'b1, "oe a set");
    chk(pwm_b_pin_oe, 1'b1, "oe b set");
    pwm_check(1'b0, 4 * c0, 4 * c0);
    // zero duty holds the inverse of polarity
    pwm_cfg(tcp_pkg::PAIR_A_BASE, 2'b00, 10'd3, 10'd0, 1'b1);
    pwm_check(1'b0, 4 * c0, 0);
    pwm_cfg(tcp_pkg::PAIR_A_BASE, 2'b00, 10'd3, 10'd0, 1'b0);
    pwm_check(1'b0, 4 * c0, 4 * c0);
    // every documented source clock on channel b, duty 3 of 4 ticks
    for (int i = 0; i < 3; i++) begin
      pwm_cfg(tcp_pkg::PAIR_B_BASE, 2'(i), 10'd3, 10'd2, 1'b1);
      pwm_check(1'b1, 40 * cyc[i], 30 * cyc[i]);
    end
    pwm_cfg(tcp_pkg::PAIR_B_BASE, 2'b00, 10'd3, 10'd2, 1'b0);
    pwm_check(1'b1, 40 * c0, 10 * c0);
    // 10-bit period 257 and duty 256, past 8 bits, through the high bits
    pwm_cfg(tcp_pkg::PAIR_A_BASE, 2'b00, 10'd257, 10'd256, 1'b1);
    pwm_check(1'b0, 258 * c0, 257 * c0);
    // duty and period changed while running, without a stop
    pwm_cfg(tcp_pkg::PAIR_A_BASE, 2'b00, 10'd3, 10'd1, 1'b1);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_HIGH_BITS), 8'h00);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_DUTY_LO), 8'h02);
    pwm_check(1'b0, 40 * c0, 30 * c0);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_PER_LO), 8'h07);
    pwm_check(1'b0, 80 * c0, 30 * c0);
    // cascaded 16-bit timer matching 0x0100 at prescale 2
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_LO_MODE), 8'h00);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_CMP_LO), 8'h00);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_CMP_HI), 8'h01);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_HI_MODE), 8'h0b);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_LO_MODE), 8'h10);
    gap(0, n);
    chk(32'(n), 32'd514, "16-bit match interval");
    // upper timers as plain 8-bit timers matching 1; lower c counts event pin edges up to 2
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_CMP_LO), 8'h02);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_CMP_HI), 8'h01);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_LO_MODE), 8'h17);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_HI_MODE), 8'h40);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_HI_MODE), 8'h40);
    gap(1, n);
    chk(32'(n), 32'(2 * c0), "upper a match interval");
    gap(3, n);
    chk(32'(n), 32'(2 * c0), "upper c match interval");
    gap(2, n);
    chk(32'(n), 32'd6, "event count match interval");
    // 16-bit capture: pair a on falling edges 1000 cycles apart, pair c on both edges 500 apart
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_LO_MODE), 8'h00);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_CMP_LO), 8'hff);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_CMP_HI), 8'hff);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_HI_MODE), 8'h0f);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_LO_MODE), 8'h00);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_CMP_LO), 8'hff);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_CMP_HI), 8'hff);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_HI_MODE), 8'h0f);
    apb_write(tcp_pkg::OFS_PORT_SEL, 8'h37);
    apb_write(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_LO_MODE), 8'h18);
    apb_write(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_LO_MODE), 8'h18);
    @(posedge pclk);
    cap_a_pin <= 1'b0;
    cap_c_pin <= 1'b1;
    repeat (500) @(posedge pclk);
    cap_a_pin <= 1'b1;
    cap_c_pin <= 1'b0;
    repeat (500) @(posedge pclk);
    cap_a_pin <= 1'b0;
    cap_c_pin <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((capture_a_event & capture_c_event) !== 1'b1 && n < 4);
    chk(32'(n < 4), 32'd1, "capture event");
    apb_xfer(1'b0, ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_CMP_LO), 8'h00, rd, er);
    chk(32'(rd >= 32'h0000_00f3 && rd <= 32'h0000_00f5), 32'd1, "capture low byte");
    apb_read(ra(tcp_pkg::PAIR_A_BASE, tcp_pkg::IDX_CMP_HI), 32'h0000_0001, "capture high byte");
    apb_xfer(1'b0, ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_CMP_LO), 8'h00, rd, er);
    chk(32'(rd >= 32'h0000_00f9 && rd <= 32'h0000_00fa), 32'd1, "both edge capture low byte");
    apb_read(ra(tcp_pkg::PAIR_B_BASE, tcp_pkg::IDX_CMP_HI), 32'h0000_0000, "both edge capture high byte");
    final_report();
  end
endmodule : tcp_timer_block_tb
